// >>> logic/sacr_pkg.sv
// Shared constants for the converter control link.
package sacr_pkg;
    // Result width and byte width.
    localparam int RESULT_W = 16;
    localparam int BYTE_W = 8;
    // Clock rate of clk_sys in kHz.
    localparam int CLK_KHZ = 50000;
    // Least convert pulse low time, in ns.
    localparam int CONV_LOW_MIN_NS = 40;
    // Longest convert pulse low time, in ns.
    localparam int CONV_LOW_MAX_NS = 12000;
    // Least spacing of convert requests, in ns.
    localparam int CONV_SPACE_NS = 25000;
    // Setup of the non-initiating input, in ns.
    localparam int PRE_LOW_NS = 10;
    // Least low time in cycles, rounded up.
    localparam int CONV_LOW_MIN_CYC = (CONV_LOW_MIN_NS * CLK_KHZ + 999999) / 1000000;
    // Longest low time in cycles, rounded down.
    localparam int CONV_LOW_MAX_CYC = (CONV_LOW_MAX_NS * CLK_KHZ) / 1000000;
    // Spacing of requests in cycles, rounded up.
    localparam int CONV_SPACE_CYC = (CONV_SPACE_NS * CLK_KHZ + 999999) / 1000000;
    // Setup in cycles, rounded up, at least one.
    localparam int PRE_LOW_CYC = (PRE_LOW_NS * CLK_KHZ + 999999) / 1000000;
    // Default conversion length and half period of the internal shift clock.
    localparam int CONV_CYC_DEF = 400;
    localparam int SHIFT_HALF_DEF = 4;
    // Synchronised host pin levels after reset, in the order chip select, read/convert,
    // byte select, clock source select, format select; idle so no start follows reset.
    localparam logic [4:0] PIN_IDLE = 5'h1A;
    // Result register value after reset.
    localparam logic [15:0] RESULT_RST = 16'h0000;
    // Straight binary offset applied to a two's complement sample.
    localparam logic [15:0] SB_OFFSET = 16'h8000;
endpackage : sacr_pkg

// >>> logic/sacr_link_if.sv
// Pin-level link between host controller and converter control.
interface sacr_link_if;
    logic chip_sel_n;        // Active-low chip select, host driven.
    logic read_conv;         // High reads, low converts, host driven.
    logic byte_sel;          // Low upper byte, high lower byte.
    logic busy_n;            // Active-low busy, device driven.
    logic [7:0] par_out;     // Device drive of parallel_result_bus.
    logic par_oe;            // Device enable of parallel_result_bus.
    logic [7:0] parallel_result_bus; // Resolved bus level.
    logic serial_result_out; // Serial data, device driven.
    logic clock_source_sel;  // Low internal shift clock, host driven.
    logic code_format_sel;   // High straight binary, host driven.
    logic shift_clk_dev_o;   // Device drive of shift_clock.
    logic shift_clk_dev_oe;  // Device enable of shift_clock.
    logic shift_clk_host_o;  // Host drive of shift_clock.
    logic shift_clk_host_oe; // Host enable of shift_clock.
    logic shift_clock;       // Resolved shift clock level.

    // Resolve the shared pins from their enables.
    assign parallel_result_bus = par_oe ? par_out : 8'hFF;
    assign shift_clock = shift_clk_dev_oe ? shift_clk_dev_o :
                         (shift_clk_host_oe ? shift_clk_host_o : 1'b0);

    // Converter end.
    modport device (
        input chip_sel_n, read_conv, byte_sel, clock_source_sel, code_format_sel,
        input shift_clock,
        output busy_n, par_out, par_oe, serial_result_out,
        output shift_clk_dev_o, shift_clk_dev_oe
    );
    // Host end.
    modport host (
        output chip_sel_n, read_conv, byte_sel, clock_source_sel, code_format_sel,
        output shift_clk_host_o, shift_clk_host_oe,
        input busy_n, parallel_result_bus, serial_result_out, shift_clock
    );
endinterface : sacr_link_if

// >>> logic/sacr_device.sv
// Converter end: convert start, busy, parallel and serial readout.
module sacr_device
    import sacr_pkg::*;
#(
    parameter int CONV_CYC = sacr_pkg::CONV_CYC_DEF,
    parameter int SHIFT_HALF = sacr_pkg::SHIFT_HALF_DEF
)
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Link pins.
    sacr_link_if.device link,
    // Sample source for each conversion, two's complement.
    input wire logic [sacr_pkg::RESULT_W-1:0] sample_in,
    // One-cycle pulse when a conversion starts.
    output logic conv_start
);
    import sacr_pkg::*;

    // Device states.
    typedef enum logic [0:0] {SACR_IDLE, SACR_CONV} sacr_state_t;

    // Two-flop synchronisers for host pins.
    logic [4:0] pin_s1_r;
    logic [4:0] pin_s2_r;
    logic cs_n;
    logic rc;
    logic bsel;
    logic src_sel;
    logic fmt_sel;
    sacr_state_t state_r;
    logic [15:0] conv_cnt_r;      // Conversion cycles remaining.
    logic conv_done_r;            // Conversion part finished.
    logic [15:0] result_r;        // Output register, two's complement.
    logic [15:0] shift_r;         // Serial shift word.
    logic [4:0] bits_left_r;      // Serial bits still to send.
    logic [7:0] half_cnt_r;       // Shift clock half-period counter.
    logic sclk_r;                 // Internal shift clock level.
    logic serial_bit_r;           // Registered serial output.
    logic [7:0] par_r;            // Registered parallel data.
    logic par_oe_r;               // Registered parallel enable.
    logic start_req;              // Both inputs low.
    logic [15:0] fmt_word;        // Result in chosen format.
    logic shift_done;

    // Synchronise host pins into clk_sys before use.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            pin_s1_r <= PIN_IDLE;
            pin_s2_r <= PIN_IDLE;
        end
        else
        begin
            pin_s1_r <= {link.chip_sel_n, link.read_conv, link.byte_sel,
                         link.clock_source_sel, link.code_format_sel};
            pin_s2_r <= pin_s1_r;
        end
    end
    assign cs_n = pin_s2_r[4];
    assign rc = pin_s2_r[3];
    assign bsel = pin_s2_r[2];
    assign src_sel = pin_s2_r[1];
    assign fmt_sel = pin_s2_r[0];

    // Level NOR of the two inputs; low on both asks to convert.
    assign start_req = ~cs_n & ~rc;
    // Format conversion by flipping the sign bit.
    assign fmt_word = fmt_sel ? (result_r ^ SB_OFFSET) : result_r;
    assign shift_done = (bits_left_r == 5'h00);

    // Convert sequencing; a request in busy is simply not looked at.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            state_r <= SACR_IDLE;
            conv_cnt_r <= 16'h0000;
            conv_done_r <= 1'b0;
            conv_start <= 1'b0;
        end
        else
        begin
            conv_start <= 1'b0;
            case (state_r)
                SACR_IDLE:
                begin
                    // A still-low pair at busy rise restarts, as the host was warned.
                    if (start_req)
                    begin
                        state_r <= SACR_CONV;
                        conv_cnt_r <= 16'(CONV_CYC);
                        conv_done_r <= 1'b0;
                        conv_start <= 1'b1;
                    end
                end
                SACR_CONV:
                begin
                    // Inputs are ignored here, so the conversion runs on.
                    if (!conv_done_r)
                    begin
                        if (conv_cnt_r <= 16'h0001)
                        begin
                            conv_done_r <= 1'b1;
                        end
                        else
                        begin
                            conv_cnt_r <= conv_cnt_r - 16'h0001;
                        end
                    end
                    else if (shift_done)
                    begin
                        state_r <= SACR_IDLE;
                    end
                end
                default:
                begin
                    state_r <= SACR_IDLE;
                end
            endcase
        end
    end

    // Load the output register once the conversion part completes.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            result_r <= RESULT_RST;
        end
        else if (state_r == SACR_CONV && !conv_done_r && conv_cnt_r <= 16'h0001)
        begin
            result_r <= sample_in;
        end
    end

    // Busy low for the whole conversion and any serial shift.
    assign link.busy_n = (state_r == SACR_IDLE);

    // Internal-clock serial shift of the previous result, 16 pulses.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            shift_r <= 16'h0000;
            bits_left_r <= 5'h00;
            half_cnt_r <= 8'h00;
            sclk_r <= 1'b0;
            serial_bit_r <= 1'b0;
        end
        else if (conv_start && !src_sel)
        begin
            // Only start matters; read/convert going high later is ignored.
            shift_r <= {fmt_word[14:0], 1'b0};
            serial_bit_r <= fmt_word[15];
            bits_left_r <= 5'h10;
            half_cnt_r <= 8'h00;
            sclk_r <= 1'b0;
        end
        else if (!shift_done)
        begin
            if (half_cnt_r == 8'(SHIFT_HALF - 1))
            begin
                half_cnt_r <= 8'h00;
                sclk_r <= ~sclk_r;
                // Data changes only with a falling edge, so it is steady across each rising edge.
                if (sclk_r)
                begin
                    bits_left_r <= bits_left_r - 5'h01;
                    serial_bit_r <= shift_r[15];
                    shift_r <= {shift_r[14:0], 1'b0};
                end
            end
            else
            begin
                half_cnt_r <= half_cnt_r + 8'h01;
            end
        end
    end
    assign link.serial_result_out = serial_bit_r;
    // Drive the shift clock pin only in internal mode.
    assign link.shift_clk_dev_o = sclk_r;
    assign link.shift_clk_dev_oe = ~src_sel;

    // Parallel bus: enabled only for chip select low and read high.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            par_r <= 8'h00;
            par_oe_r <= 1'b0;
        end
        else
        begin
            par_oe_r <= ~cs_n & rc;
            // Result register updates only at conversion end, so busy shows old data.
            par_r <= bsel ? fmt_word[7:0] : fmt_word[15:8];
        end
    end
    assign link.par_out = par_r;
    assign link.par_oe = par_oe_r;
endmodule : sacr_device

// >>> logic/sacr_host.sv
// Host end: issues convert requests and reads back results.
module sacr_host
    import sacr_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Link pins.
    sacr_link_if.host link,
    // User side.
    input wire logic conv_req,
    input wire logic serial_mode,
    input wire logic fmt_straight,
    output logic req_ready,
    output logic [sacr_pkg::RESULT_W-1:0] result_data,
    output logic result_valid
);
    import sacr_pkg::*;

    // Host states.
    typedef enum logic [2:0] {SACH_IDLE, SACH_PRE, SACH_LOW, SACH_WAIT,
                              SACH_RD_HI, SACH_RD_LO, SACH_GAP} sach_state_t;

    sach_state_t state_r;
    logic [15:0] cnt_r;            // Phase timer.
    logic [15:0] space_r;          // Spacing timer between requests.
    logic [1:0] busy_s_r;          // Busy synchroniser.
    logic [7:0] bus_s1_r;
    logic [7:0] bus_s2_r;
    logic mode_r;
    logic cs_n_r;
    logic rc_r;
    logic bsel_r;
    logic [2:0] sclk_s_r;          // Shift clock synchroniser and edge history.
    logic [1:0] sdat_s_r;          // Serial data synchroniser.
    logic [15:0] ser_r;            // Serial word gathered from the device.

    // Synchronise device outputs.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            busy_s_r <= 2'b11;
            bus_s1_r <= 8'h00;
            bus_s2_r <= 8'h00;
            sclk_s_r <= 3'h0;
            sdat_s_r <= 2'h0;
        end
        else
        begin
            busy_s_r <= {busy_s_r[0], link.busy_n};
            bus_s1_r <= link.parallel_result_bus;
            bus_s2_r <= bus_s1_r;
            sclk_s_r <= {sclk_s_r[1:0], link.shift_clock};
            sdat_s_r <= {sdat_s_r[0], link.serial_result_out};
        end
    end

    // Take one bit per synchronised rising shift clock; clock and data share one
    // delay, so the bit is taken well inside the time that it stands.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            ser_r <= 16'h0000;
        end
        else if (sclk_s_r[1] && !sclk_s_r[2])
        begin
            ser_r <= {ser_r[14:0], sdat_s_r[1]};
        end
    end

    // Sequencer: chip select low first, then read/convert initiates.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            state_r <= SACH_IDLE;
            cnt_r <= 16'h0000;
            space_r <= 16'h0000;
            mode_r <= 1'b0;
            cs_n_r <= 1'b1;
            rc_r <= 1'b1;
            bsel_r <= 1'b0;
            result_data <= 16'h0000;
            result_valid <= 1'b0;
        end
        else
        begin
            result_valid <= 1'b0;
            if (space_r != 16'h0000)
            begin
                space_r <= space_r - 16'h0001;
            end
            case (state_r)
                SACH_IDLE:
                begin
                    if (conv_req && space_r == 16'h0000)
                    begin
                        mode_r <= serial_mode;
                        cs_n_r <= 1'b0;
                        cnt_r <= 16'(PRE_LOW_CYC);
                        state_r <= SACH_PRE;
                    end
                end
                SACH_PRE:
                begin
                    if (cnt_r <= 16'h0001)
                    begin
                        rc_r <= 1'b0;
                        space_r <= 16'(CONV_SPACE_CYC);
                        cnt_r <= 16'(CONV_LOW_MIN_CYC);
                        state_r <= SACH_LOW;
                    end
                    else
                    begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                SACH_LOW:
                begin
                    // Release well inside the longest low time, before busy rises.
                    if (cnt_r <= 16'h0001)
                    begin
                        rc_r <= 1'b1;
                        cs_n_r <= mode_r;
                        cnt_r <= 16'h0004;
                        state_r <= SACH_WAIT;
                    end
                    else
                    begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                SACH_WAIT:
                begin
                    if (cnt_r != 16'h0000)
                    begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                    else if (busy_s_r[1])
                    begin
                        bsel_r <= 1'b0;
                        // Five waits cover device sync, its bus flop and our own sync.
                        cnt_r <= 16'h0005;
                        state_r <= mode_r ? SACH_GAP : SACH_RD_HI;
                    end
                end
                SACH_RD_HI:
                begin
                    if (cnt_r != 16'h0000)
                    begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                    else
                    begin
                        result_data[15:8] <= bus_s2_r;
                        bsel_r <= 1'b1;
                        cnt_r <= 16'h0005;
                        state_r <= SACH_RD_LO;
                    end
                end
                SACH_RD_LO:
                begin
                    if (cnt_r != 16'h0000)
                    begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                    else
                    begin
                        result_data[7:0] <= bus_s2_r;
                        result_valid <= 1'b1;
                        cs_n_r <= 1'b1;
                        state_r <= SACH_GAP;
                    end
                end
                SACH_GAP:
                begin
                    cs_n_r <= 1'b1;
                    // Serial mode hands over the gathered word once busy has risen.
                    if (mode_r)
                    begin
                        result_data <= ser_r;
                        result_valid <= 1'b1;
                    end
                    state_r <= SACH_IDLE;
                end
                default:
                begin
                    state_r <= SACH_IDLE;
                end
            endcase
        end
    end

    assign req_ready = (state_r == SACH_IDLE) && (space_r == 16'h0000);
    assign link.chip_sel_n = cs_n_r;
    assign link.read_conv = rc_r;
    assign link.byte_sel = bsel_r;
    // Parallel use keeps source select high and the clock pin low.
    assign link.clock_source_sel = ~mode_r;
    assign link.shift_clk_host_o = 1'b0;
    assign link.shift_clk_host_oe = ~mode_r;
    assign link.code_format_sel = fmt_straight;
endmodule : sacr_host

// >>> tb/sacr_props.sv
// Concurrent checks on the pins of the link that joins host and converter ends.
module sacr_props
#(
    parameter int CONV_CYC = 20,
    parameter int SHIFT_HALF = 2
)
(
    // Clock and reset.
    input logic clk_sys,
    input logic reset,
    // Host driven pins.
    input logic chip_sel_n,
    input logic read_conv,
    input logic byte_sel,
    input logic clock_source_sel,
    // Converter driven pins.
    input logic busy_n,
    input logic [7:0] par_out,
    input logic par_oe,
    input logic serial_result_out,
    input logic shift_clk_dev_o,
    input logic shift_clk_dev_oe
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    logic [15:0] low_cnt_r; // Cycles with busy low, cleared while busy is high.
    logic [5:0] pulse_cnt_r; // Shift clock rising edges seen while busy is low.
    logic shift_prev_r; // Shift clock level one cycle back.

    // Busy length is counted, so long waits need no long repetition.
    always_ff @(posedge clk_sys)
        low_cnt_r <= (reset || busy_n) ? 16'h0000 : low_cnt_r + 16'h0001;

    // Previous shift clock level, used to find its rising edges.
    always_ff @(posedge clk_sys)
        shift_prev_r <= reset ? 1'b0 : shift_clk_dev_o;

    // Pulses of one frame; the frame ends before busy rises.
    always_ff @(posedge clk_sys)
        pulse_cnt_r <= (reset || busy_n) ? 6'h00 :
                       pulse_cnt_r + {5'h00, shift_clk_dev_o && !shift_prev_r};

    start_takes_a: assert property (
        (!chip_sel_n && !read_conv) [*2] |-> ##[0:5] !busy_n)
        else $error("start did not lower busy");
    busy_length_a: assert property (
        $rose(busy_n) && clock_source_sel |-> low_cnt_r >= CONV_CYC - 1 && low_cnt_r <= CONV_CYC + 1)
        else $error("busy low length off");
    busy_holds_a: assert property (
        !busy_n && low_cnt_r < CONV_CYC - 2 |=> !busy_n)
        else $error("busy released early");
    frame_pulses_a: assert property (
        $rose(busy_n) && !clock_source_sel |-> pulse_cnt_r == 6'h10)
        else $error("shift pulse count off");
    bit_stable_a: assert property (
        shift_clk_dev_oe && shift_clk_dev_o |-> $stable(serial_result_out))
        else $error("serial bit moved while shift clock high");
    clock_dir_a: assert property (
        clock_source_sel [*4] |-> !shift_clk_dev_oe)
        else $error("shift clock driven in external mode");
    deselect_idle_a: assert property (
        chip_sel_n [*4] |-> !par_oe)
        else $error("bus driven while deselected");
    convert_idle_a: assert property (
        !read_conv [*2] |-> ##2 !par_oe)
        else $error("bus driven while converting");
    read_enable_a: assert property (
        (!chip_sel_n && read_conv) [*4] |-> par_oe)
        else $error("bus not driven on read");
    result_steady_a: assert property (
        (busy_n && par_oe && $stable(byte_sel)) [*4] |-> $stable(par_out))
        else $error("settled bus changed");
endmodule : sacr_props

// >>> tb/sacr_tb.sv
// Self-checking bench: host and converter ends joined, plus a rule-breaking driver.
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_fail++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module sacr_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CONV_CYC = 20; // Short conversion keeps the run brief.
    localparam int SHIFT_HALF = 2; // Short shift clock half period.
    logic clk_sys = 1'b0; // System clock.
    logic reset = 1'b1; // Synchronous reset.
    logic conv_req = 1'b0; // Host user request.
    logic serial_mode = 1'b0; // Host readout mode.
    logic fmt_straight = 1'b0; // Host code format.
    logic req_ready; // Host accepts a request.
    logic [15:0] result_data; // Host result.
    logic result_valid; // Host result strobe.
    logic [15:0] sample_in = 16'h0000; // Sample for the joined converter.
    logic [15:0] sample2 = 16'h0000; // Sample for the driven converter.
    logic start2; // Start pulse of the driven converter.
    int n_start2 = 0; // Starts of the driven converter.
    logic [7:0] mon_hi = 8'h00; // Last upper byte seen on the bus.
    logic [7:0] mon_lo = 8'h00; // Last lower byte seen on the bus.
    logic [15:0] ser_word = 16'h0000; // Serial bits taken at rising shift clock.
    int ser_cnt = 0; // Shift clock rising edges in a frame.
    int n_fail = 0;
    int checked = 0;

    sacr_link_if link ();
    sacr_link_if link2 ();

    sacr_device #(.CONV_CYC(CONV_CYC), .SHIFT_HALF(SHIFT_HALF)) u_sacr_device (.clk_sys(clk_sys),
        .reset(reset), .link(link), .sample_in(sample_in), .conv_start());
    sacr_host u_sacr_host (.clk_sys(clk_sys), .reset(reset), .link(link), .conv_req(conv_req),
        .serial_mode(serial_mode), .fmt_straight(fmt_straight), .req_ready(req_ready),
        .result_data(result_data), .result_valid(result_valid));
    // Second converter, driven by the bench in the host's place.
    sacr_device #(.CONV_CYC(CONV_CYC), .SHIFT_HALF(SHIFT_HALF)) u_sacr_device_2 (
        .clk_sys(clk_sys), .reset(reset), .link(link2), .sample_in(sample2), .conv_start(start2));
    sacr_props #(.CONV_CYC(CONV_CYC), .SHIFT_HALF(SHIFT_HALF)) u_sacr_props (.clk_sys(clk_sys),
        .reset(reset), .chip_sel_n(link.chip_sel_n), .read_conv(link.read_conv),
        .byte_sel(link.byte_sel), .clock_source_sel(link.clock_source_sel),
        .busy_n(link.busy_n), .par_out(link.par_out), .par_oe(link.par_oe),
        .serial_result_out(link.serial_result_out), .shift_clk_dev_o(link.shift_clk_dev_o),
        .shift_clk_dev_oe(link.shift_clk_dev_oe));

    // Idle host pins of the driven link; external clock mode stays parked.
    initial
    begin
        link2.chip_sel_n = 1'b1;
        link2.read_conv = 1'b1;
        link2.byte_sel = 1'b0;
        link2.clock_source_sel = 1'b1;
        link2.code_format_sel = 1'b0;
        link2.shift_clk_host_o = 1'b0;
        link2.shift_clk_host_oe = 1'b0;
    end

    // Free running system clock.
    always #10 clk_sys = ~clk_sys;

    // Count starts of the driven converter.
    always @(posedge clk_sys)
        if (start2 === 1'b1)
            n_start2 <= n_start2 + 1;

    // Keep the last bytes read on the joined bus while a read is settled.
    always @(posedge clk_sys)
        if (link.par_oe && link.busy_n && !link.chip_sel_n && link.read_conv)
        begin
            if (link.byte_sel)
                mon_lo <= link.parallel_result_bus;
            else
                mon_hi <= link.parallel_result_bus;
        end

    // Take serial bits on the rising shift clock; they are held across it.
    always @(posedge link.shift_clock)
    begin
        ser_word <= {ser_word[14:0], link.serial_result_out};
        ser_cnt <= ser_cnt + 1;
    end

    // Print the counts and the verdict, then stop.
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    // Wait, bounded, for the driven converter's busy to reach a level.
    task automatic wait_busy2(input logic lvl);
        int i;
        for (i = 0; i < 300 && link2.busy_n !== lvl; i++)
            @(negedge clk_sys);
        if (link2.busy_n !== lvl)
        begin
            n_fail++;
            $display("MISMATCH busy wait exp %h got %h", lvl, link2.busy_n);
            final_report();
        end
    endtask : wait_busy2

    // One request through the host end, judged on the result it returns.
    task automatic run_conv(input logic [15:0] smp, input logic fmt, input logic ser,
                            input logic [15:0] exp);
        int i;
        @(negedge clk_sys);
        sample_in = smp;
        fmt_straight = fmt;
        serial_mode = ser;
        ser_cnt = 0;
        conv_req = 1'b1;
        for (i = 0; i < 3000 && req_ready !== 1'b1; i++)
            @(negedge clk_sys);
        @(negedge clk_sys);
        conv_req = 1'b0;
        for (i = 0; i < 3000 && result_valid !== 1'b1; i++)
            @(negedge clk_sys);
        `CHK("result", exp, result_data)
        if (result_valid !== 1'b1)
        begin
            n_fail++;
            $display("MISMATCH result wait exp 1 got %b", result_valid);
            final_report();
        end
    endtask : run_conv

    // Parallel reads in both code formats.
    task automatic sc_parallel();
        run_conv(16'h1234, 1'b0, 1'b0, 16'h1234);
        `CHK("upper byte", 8'h12, mon_hi)
        `CHK("lower byte", 8'h34, mon_lo)
        run_conv(16'h0001, 1'b1, 1'b0, 16'h8001);
        `CHK("upper byte sb", 8'h80, mon_hi)
    endtask : sc_parallel

    // Serial frames carry the result of the conversion before.
    task automatic sc_serial();
        run_conv(16'hA5C3, 1'b0, 1'b1, 16'h0001);
        `CHK("serial word", 16'h0001, ser_word)
        `CHK("shift pulses", 16, ser_cnt)
        run_conv(16'h5A3C, 1'b0, 1'b1, 16'hA5C3);
    endtask : sc_serial

    // A request during busy is ignored; then bytes and idle bus.
    task automatic sc_ignore();
        int s0;
        s0 = n_start2;
        sample2 = 16'h2468;
        link2.chip_sel_n = 1'b0;
        @(negedge clk_sys);
        link2.read_conv = 1'b0;
        repeat (3) @(negedge clk_sys);
        link2.read_conv = 1'b1;
        wait_busy2(1'b0);
        link2.read_conv = 1'b0;
        repeat (3) @(negedge clk_sys);
        link2.read_conv = 1'b1;
        wait_busy2(1'b1);
        `CHK("starts", s0 + 1, n_start2)
        repeat (4) @(negedge clk_sys);
        `CHK("bus upper", 8'h24, link2.parallel_result_bus)
        link2.byte_sel = 1'b1;
        repeat (4) @(negedge clk_sys);
        `CHK("bus lower", 8'h68, link2.parallel_result_bus)
        link2.chip_sel_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        `CHK("bus idle", 8'hFF, link2.parallel_result_bus)
    endtask : sc_ignore

    // Reading during a conversion shows the older result; select stays low.
    task automatic sc_read_during();
        sample2 = 16'h1357;
        link2.chip_sel_n = 1'b0;
        link2.read_conv = 1'b0;
        repeat (3) @(negedge clk_sys);
        link2.read_conv = 1'b1;
        wait_busy2(1'b0);
        repeat (4) @(negedge clk_sys);
        `CHK("bus previous", 8'h68, link2.parallel_result_bus)
        wait_busy2(1'b1);
        repeat (4) @(negedge clk_sys);
        `CHK("bus latest", 8'h57, link2.parallel_result_bus)
    endtask : sc_read_during

    // Both inputs held low past busy rising: a second start follows at once.
    task automatic sc_stuck();
        int s0;
        s0 = n_start2;
        link2.read_conv = 1'b0;
        wait_busy2(1'b0);
        repeat (2) @(negedge clk_sys);
        `CHK("bus on convert", 8'hFF, link2.parallel_result_bus)
        wait_busy2(1'b1);
        repeat (6) @(negedge clk_sys);
        `CHK("restart", s0 + 2, n_start2)
        link2.read_conv = 1'b1;
        link2.chip_sel_n = 1'b1;
        wait_busy2(1'b1);
    endtask : sc_stuck

    // Main sequence.
    initial
    begin
        repeat (6) @(negedge clk_sys);
        reset = 1'b0;
        sc_parallel();
        sc_serial();
        sc_ignore();
        sc_read_during();
        sc_stuck();
        repeat (10) @(negedge clk_sys);
        final_report();
    end
endmodule : sacr_tb
